// ### hdl/sfspi_front_end.sv
// pin-level serial front end of the flash: framing, shifting, dual output
module sfspi_front_end
  import sfspi_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic csPinN,
  input wire logic sckPin,
  input wire logic dualDataLowLineIn,
  output logic dualDataLowLineOut,
  output logic dualDataLowLineOe,
  output logic dualDataHighLineOut,
  output logic dualDataHighLineOe,
  output logic rxValid,
  output sfspi_rx_t rxWord,
  input wire logic rxReady,
  input wire logic txValid,
  input wire sfspi_tx_t txWord,
  output logic txReady,
  input wire logic internalBusy,
  output logic opStart,
  output logic opEnd,
  output logic selected,
  output logic standby
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] syncA_reg, syncA_next;
  logic [2:0] syncB_reg, syncB_next;
  logic csS, sckS, siS, csPrev_reg, csPrev_next, sckPrev_reg, sckPrev_next;

  always_comb begin
    syncA_next = {csPinN, sckPin, dualDataLowLineIn};
    syncB_next = syncA_reg;
    csPrev_next = syncB_reg[2];
    sckPrev_next = syncB_reg[1];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      syncA_reg <= SFSPI_SYNC_RST;
      syncB_reg <= SFSPI_SYNC_RST;
      csPrev_reg <= 1'b1;
      sckPrev_reg <= 1'b1;
    end else begin
      syncA_reg <= syncA_next;
      syncB_reg <= syncB_next;
      csPrev_reg <= csPrev_next;
      sckPrev_reg <= sckPrev_next;
    end
  end

  assign csS = syncB_reg[2];
  assign sckS = syncB_reg[1];
  assign siS = syncB_reg[0];

  logic csFall, csRise, sckRise, sckFall;
  assign csFall = csPrev_reg & ~csS;
  assign csRise = ~csPrev_reg & csS;
  // edges only count while selected; idle level of sck is irrelevant
  assign sckRise = ~csS & ~sckPrev_reg & sckS;
  assign sckFall = ~csS & sckPrev_reg & ~sckS;

  // ----------------------------------------
  // receive buffer, two entries
  // ----------------------------------------
  sfspi_rx_t buf_reg [2];
  sfspi_rx_t buf_next [2];
  logic [1:0] cnt_reg, cnt_next;
  logic push, rxValid_reg, rxValid_next;
  sfspi_rx_t pushWord;

  always_comb begin
    buf_next = buf_reg;
    cnt_next = cnt_reg;
    if (rxValid && rxReady) begin
      buf_next[0] = buf_reg[1];
      cnt_next = cnt_next - 2'h1;
    end
    if (push && cnt_reg != 2'h2) begin
      buf_next[cnt_next[0]] = pushWord;
      cnt_next = cnt_next + 2'h1;
    end
    rxValid_next = cnt_next != 2'h0;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
      cnt_reg <= 2'h0;
      rxValid_reg <= 1'b0;
    end else begin
      buf_reg <= buf_next;
      cnt_reg <= cnt_next;
      rxValid_reg <= rxValid_next;
    end
  end

  assign rxValid = rxValid_reg;
  assign rxWord = buf_reg[0];

  // ----------------------------------------
  // framing and shifting
  // ----------------------------------------
  sfspi_state_t state_reg, state_next;
  logic [2:0] rxCnt_reg, rxCnt_next, txCnt_reg, txCnt_next;
  logic [7:0] rxSh_reg, rxSh_next, txSh_reg, txSh_next;
  logic firstByte_reg, firstByte_next, dual_reg, dual_next, txLoaded_reg, txLoaded_next;
  logic loOut_reg, loOut_next, loOe_reg, loOe_next, hiOut_reg, hiOut_next;
  logic hiOe_reg, hiOe_next, start_reg, start_next, end_reg, end_next;
  logic txReady_reg, txReady_next, txRun_reg, txRun_next, txShift;
  assign txShift = sckFall & txLoaded_reg
    & (txRun_reg | (rxCnt_reg == SFSPI_CNT_RST & ~firstByte_reg));

  always_comb begin
    state_next = state_reg;
    rxCnt_next = rxCnt_reg;
    rxSh_next = rxSh_reg;
    txCnt_next = txCnt_reg;
    txSh_next = txSh_reg;
    firstByte_next = firstByte_reg;
    dual_next = dual_reg;
    txLoaded_next = txLoaded_reg;
    loOut_next = loOut_reg;
    loOe_next = loOe_reg;
    hiOut_next = hiOut_reg;
    hiOe_next = hiOe_reg;
    start_next = 1'b0;
    end_next = 1'b0;
    txReady_next = 1'b0;
    txRun_next = txRun_reg;
    push = 1'b0;
    pushWord = {rxSh_next, firstByte_reg};
    case (state_reg)
      SFSPI_STANDBY, SFSPI_BUSY_WAIT: begin
        if (state_reg == SFSPI_BUSY_WAIT && !internalBusy) begin
          state_next = SFSPI_STANDBY;
        end
        if (csFall) begin
          state_next = SFSPI_ACTIVE;
          start_next = 1'b1;
          rxCnt_next = SFSPI_CNT_RST;
          txCnt_next = SFSPI_CNT_RST;
          firstByte_next = 1'b1;
          txLoaded_next = 1'b0;
          dual_next = 1'b0;
          txRun_next = 1'b0;
        end
      end
      SFSPI_ACTIVE: begin
        if (!txLoaded_reg && txValid) begin
          txSh_next = txWord.data;
          dual_next = txWord.dual;
          txLoaded_next = 1'b1;
          txReady_next = 1'b1;
        end
        if (sckRise) begin
          rxSh_next = {rxSh_reg[6:0], siS};
          rxCnt_next = rxCnt_reg + 3'h1;
          if (rxCnt_reg == SFSPI_BIT_LAST) begin
            push = ~dual_reg;
            pushWord = {rxSh_next, firstByte_reg};
            firstByte_next = 1'b0;
          end
        end
        if (txShift) begin
          txRun_next = 1'b1;
          if (dual_reg) begin
            hiOut_next = txSh_reg[7];
            loOut_next = txSh_reg[6];
            loOe_next = 1'b1;
            hiOe_next = 1'b1;
            txSh_next = {txSh_reg[5:0], 2'b00};
            txCnt_next = txCnt_reg + 3'h1;
            if (txCnt_reg == SFSPI_PAIR_LAST) begin
              txLoaded_next = 1'b0;
              txCnt_next = SFSPI_CNT_RST;
            end
          end else begin
            hiOut_next = txSh_reg[7];
            hiOe_next = 1'b1;
            txSh_next = {txSh_reg[6:0], 1'b0};
            txCnt_next = txCnt_reg + 3'h1;
            if (txCnt_reg == SFSPI_BIT_LAST) begin
              txLoaded_next = 1'b0;
            end
          end
        end
        if (csRise) begin
          end_next = 1'b1;
          loOe_next = 1'b0;
          hiOe_next = 1'b0;
          txLoaded_next = 1'b0;
          txRun_next = 1'b0;
          state_next = internalBusy ? SFSPI_BUSY_WAIT : SFSPI_STANDBY;
        end
      end
      default: begin
        state_next = SFSPI_STANDBY;
        loOe_next = 1'b0;
        hiOe_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= SFSPI_STANDBY;
      rxCnt_reg <= SFSPI_CNT_RST;
      txCnt_reg <= SFSPI_CNT_RST;
      rxSh_reg <= SFSPI_BYTE_RST;
      txSh_reg <= SFSPI_BYTE_RST;
      firstByte_reg <= 1'b0;
      dual_reg <= 1'b0;
      txLoaded_reg <= 1'b0;
      loOut_reg <= 1'b0;
      loOe_reg <= 1'b0;
      hiOut_reg <= 1'b0;
      hiOe_reg <= 1'b0;
      start_reg <= 1'b0;
      end_reg <= 1'b0;
      txReady_reg <= 1'b0;
      txRun_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rxCnt_reg <= rxCnt_next;
      txCnt_reg <= txCnt_next;
      rxSh_reg <= rxSh_next;
      txSh_reg <= txSh_next;
      firstByte_reg <= firstByte_next;
      dual_reg <= dual_next;
      txLoaded_reg <= txLoaded_next;
      loOut_reg <= loOut_next;
      loOe_reg <= loOe_next;
      hiOut_reg <= hiOut_next;
      hiOe_reg <= hiOe_next;
      start_reg <= start_next;
      end_reg <= end_next;
      txReady_reg <= txReady_next;
      txRun_reg <= txRun_next;
    end
  end

  assign dualDataLowLineOut = loOut_reg;
  assign dualDataLowLineOe = loOe_reg;
  assign dualDataHighLineOut = hiOut_reg;
  assign dualDataHighLineOe = hiOe_reg;
  assign txReady = txReady_reg;
  assign opStart = start_reg;
  assign opEnd = end_reg;
  assign selected = state_reg[1];
  assign standby = state_reg[0];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_deselect_release: assert property (@(posedge ref_clk) disable iff (rst)
    (csRise && state_reg == SFSPI_ACTIVE) |=> (!dualDataHighLineOe && !dualDataLowLineOe))
    else $error("output enables not released after deselect");
  a_idle_no_drive: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg != SFSPI_ACTIVE) |-> !dualDataHighLineOe)
    else $error("output pin driven while deselected");
  a_start_edge: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(selected) |-> opStart)
    else $error("selection without start pulse");
  a_end_standby: assert property (@(posedge ref_clk) disable iff (rst)
    (csRise && state_reg == SFSPI_ACTIVE && !internalBusy) |=> standby && opEnd)
    else $error("no standby after deselect");
  a_busy_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == SFSPI_BUSY_WAIT && internalBusy && !csFall) |=> !standby)
    else $error("standby entered while busy");
  a_idle_no_rx: assert property (@(posedge ref_clk) disable iff (rst)
    (!selected && !csFall) |=> ($stable(rxSh_reg) && $stable(rxCnt_reg)))
    else $error("bit accepted while deselected");
  a_out_on_fall: assert property (@(posedge ref_clk) disable iff (rst)
    ($changed(dualDataHighLineOut) && selected) |-> $past(sckFall))
    else $error("output changed without falling clock");
  a_dual_drive: assert property (@(posedge ref_clk) disable iff (rst)
    (selected && dual_reg && txShift) |=> dualDataLowLineOe)
    else $error("low line not driven in dual read");

endmodule

// ### hdl/sfspi_pkg.sv
// package of constants and carrier types for the serial flash front end
package sfspi_pkg;

  // ----------------------------------------
  // sizes and reset values
  // ----------------------------------------
  localparam int SFSPI_BYTE_W = 8;
  localparam int SFSPI_BIT_CNT_W = 3;
  localparam logic [2:0] SFSPI_BIT_LAST = 3'h7;
  localparam logic [2:0] SFSPI_PAIR_LAST = 3'h3;
  localparam logic [2:0] SFSPI_CNT_RST = 3'h0;
  localparam logic [7:0] SFSPI_BYTE_RST = 8'h00;
  localparam int SFSPI_SYNC_STAGES = 2;
  localparam logic [2:0] SFSPI_SYNC_RST = 3'h7;

  // ----------------------------------------
  // carrier types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic first;
  } sfspi_rx_t;

  typedef struct packed {
    logic [7:0] data;
    logic dual;
  } sfspi_tx_t;

  typedef enum logic [3:0] {
    SFSPI_STANDBY = 4'h1,
    SFSPI_ACTIVE = 4'h2,
    SFSPI_BUSY_WAIT = 4'h4,
    SFSPI_SPARE = 4'h8
  } sfspi_state_t;

endpackage

// ### verif/sfspi_host_model.sv
// host controller model driving select, clock and serial input
module sfspi_host_model (
  output logic csPinN,
  output logic sckPin,
  output logic siOut,
  output logic siOe,
  input wire logic soPin,
  input wire logic siPin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mode3;
  initial begin
    csPinN = 1'b1;
    sckPin = 1'b0;
    siOut = 1'b0;
    siOe = 1'b1;
    mode3 = 1'b0;
  end
  // ----------------------------------------
  // framing and bit transfer
  // ----------------------------------------
  task automatic frame_start(input logic m3);
    mode3 = m3;
    sckPin = m3;
    #200;
    csPinN = 1'b0;
    #400;
  endtask
  task automatic xfer(input logic [7:0] mosi, input logic dual, output logic [7:0] miso);
    int n;
    n = dual ? 4 : 8;
    siOe = !dual;
    miso = 8'h00;
    for (int i = 0; i < n; i++) begin
      sckPin = 1'b0;
      siOut = mosi[7 - i];
      #160;
      sckPin = 1'b1;
      #150;
      miso = dual ? {miso[5:0], soPin, siPin} : {miso[6:0], soPin};
      #10;
    end
    sckPin = mode3;
  endtask
  task automatic frame_end();
    #200;
    csPinN = 1'b1;
    #400;
    siOe = 1'b1;
  endtask
endmodule

// ### verif/sfspi_front_end_test.sv
// self-checking bench of the serial flash front end
module sfspi_front_end_test;
  import sfspi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, csPinN, sckPin, siPin, soPin, hostSiOut, hostSiOe, floatPat;
  logic lowOut, lowOe, highOut, highOe, rxValid, rxReady, txValid, txReady;
  logic internalBusy, selected, standby, opStart, opEnd;
  sfspi_rx_t rxWord;
  sfspi_tx_t txWord;
  logic [7:0] got;
  int n_fail, n_compared, startCnt, endCnt;
  // released lines show a pattern that changes every cycle
  assign siPin = lowOe ? lowOut : (hostSiOe ? hostSiOut : floatPat);
  assign soPin = highOe ? highOut : floatPat;
  sfspi_front_end sfspi_front_end_inst (.ref_clk(ref_clk), .rst(rst), .csPinN(csPinN),
    .sckPin(sckPin), .dualDataLowLineIn(siPin), .dualDataLowLineOut(lowOut),
    .dualDataLowLineOe(lowOe), .dualDataHighLineOut(highOut), .dualDataHighLineOe(highOe),
    .rxValid(rxValid), .rxWord(rxWord), .rxReady(rxReady), .txValid(txValid),
    .txWord(txWord), .txReady(txReady), .internalBusy(internalBusy), .opStart(opStart),
    .opEnd(opEnd), .selected(selected), .standby(standby));
  sfspi_host_model sfspi_host_model_inst (.csPinN(csPinN), .sckPin(sckPin),
    .siOut(hostSiOut), .siOe(hostSiOe), .soPin(soPin), .siPin(siPin));
  always #20 ref_clk = ~ref_clk;
  always_ff @(posedge ref_clk) floatPat <= ~floatPat;
  // count one-cycle start and end pulses
  always @(posedge ref_clk) begin
    if (opStart === 1'b1) startCnt <= startCnt + 1;
    if (opEnd === 1'b1) endCnt <= endCnt + 1;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic offer(input logic [7:0] d, input logic dual);
    @(posedge ref_clk) #2;
    txValid = 1'b1;
    txWord = '{data: d, dual: dual};
    for (int i = 0; i < 400 && txReady !== 1'b1; i++) begin
      @(posedge ref_clk);
      #2;
    end
    chk(txReady === 1'b1, "tx byte not taken");
    txValid = 1'b0;
  endtask
  task automatic pop(input logic [7:0] d, input logic f);
    @(posedge ref_clk) #2;
    for (int i = 0; i < 50 && rxValid !== 1'b1; i++) begin
      @(posedge ref_clk);
      #2;
    end
    chk(rxValid === 1'b1 && rxWord === sfspi_rx_t'{data: d, first: f}, "rx word");
    rxReady = 1'b1;
    @(posedge ref_clk) #2 rxReady = 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_idle();
    sfspi_host_model_inst.xfer(8'hA5, 1'b0, got);
    repeat (10) @(posedge ref_clk);
    chk(rxValid === 1'b0, "bits taken while deselected");
    chk({highOe, lowOe} === 2'b00, "pins driven while deselected");
    chk({standby, selected} === 2'b10, "not in standby");
  endtask
  task automatic t_single(input logic m3, input logic [7:0] tx, input logic [7:0] rx);
    int s0, e0;
    s0 = startCnt;
    e0 = endCnt;
    fork
      offer(tx, 1'b0);
      sfspi_host_model_inst.frame_start(m3);
    join
    chk(selected === 1'b1, "not selected");
    // first byte is the command; output starts on the second byte
    sfspi_host_model_inst.xfer(rx, 1'b0, got);
    sfspi_host_model_inst.xfer(~rx, 1'b0, got);
    chk(got === tx, "output byte");
    sfspi_host_model_inst.frame_end();
    chk({standby, highOe} === 2'b10, "frame not ended");
    chk(startCnt == s0 + 1 && endCnt == e0 + 1, "start or end pulse count");
    pop(rx, 1'b1);
    pop(~rx, 1'b0);
  endtask
  task automatic t_buffer();
    sfspi_host_model_inst.frame_start(1'b0);
    sfspi_host_model_inst.xfer(8'h11, 1'b0, got);
    sfspi_host_model_inst.xfer(8'h22, 1'b0, got);
    sfspi_host_model_inst.xfer(8'h33, 1'b0, got);
    sfspi_host_model_inst.frame_end();
    pop(8'h11, 1'b1);
    pop(8'h22, 1'b0);
    chk(rxValid === 1'b0, "word past full buffer kept");
  endtask
  task automatic t_dual();
    fork
      offer(8'hB4, 1'b1);
      sfspi_host_model_inst.frame_start(1'b0);
    join
    sfspi_host_model_inst.xfer(8'h3B, 1'b0, got);
    sfspi_host_model_inst.xfer(8'h00, 1'b1, got);
    chk({lowOe, highOe} === 2'b11, "dual pins not driven");
    chk(got === 8'hB4, "dual byte order");
    sfspi_host_model_inst.frame_end();
    chk(lowOe === 1'b0, "input pin still driven");
    chk(rxValid === 1'b0, "byte pushed during dual read");
  endtask
  task automatic t_busy();
    @(posedge ref_clk) #2 internalBusy = 1'b1;
    sfspi_host_model_inst.frame_start(1'b1);
    sfspi_host_model_inst.xfer(8'h5A, 1'b0, got);
    sfspi_host_model_inst.frame_end();
    chk(standby === 1'b0, "standby during busy");
    @(posedge ref_clk) #2 internalBusy = 1'b0;
    repeat (10) @(posedge ref_clk);
    chk(standby === 1'b1, "no standby after busy");
    pop(8'h5A, 1'b1);
  endtask
  initial begin
    ref_clk = 1'b0;
    floatPat = 1'b0;
    rst = 1'b1;
    rxReady = 1'b0;
    txValid = 1'b0;
    txWord = '0;
    internalBusy = 1'b0;
    n_fail = 0;
    n_compared = 0;
    startCnt = 0;
    endCnt = 0;
    repeat (12) @(posedge ref_clk);
    #2 rst = 1'b0;
    repeat (3) @(posedge ref_clk);
    t_idle();
    t_single(1'b0, 8'hA5, 8'h3C);
    t_single(1'b1, 8'h96, 8'hC3);
    t_buffer();
    t_dual();
    t_busy();
    complete_run();
  end
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
endmodule
